// ===== include/cdspc_pkg.sv
// package: constants and types for the clock divider, sync and power control block
//
// Overview of operation
// - divide input clock by ratio one to eight
// - valid alignment pulse resets divider to initial state
// - sync register bits pick every-pulse or first-pulse realign
// - power-down from pin high or register request
// - pin low again resumes normal conversion
// - outputs high impedance while powered down
// - three-bit field selects power saving mode
// - standby keeps reference powered, faster wake
// - wake-up time scales with time powered down
// - stabiliser retimes falling edge to fifty percent
// - stabiliser inactive below twenty megahertz input; the code sets it by its pin alone and never checks the input rate
// - sample taken on rising conversion clock edge
package cdspc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [8:0] POWER_MODE_SELECT_OFS = 9'h100;
	localparam logic [8:0] DIVIDER_SYNC_CONTROL_OFS = 9'h109;
	localparam logic [7:0] POWER_MODE_SELECT_RST = 8'h00;
	localparam logic [7:0] DIVIDER_SYNC_CONTROL_RST = 8'h00;
	// power_mode_select fields
	localparam int PWR_MODE_LSB = 0;
	localparam int PWR_MODE_W = 3;
	localparam logic [2:0] PWR_MODE_NORMAL = 3'h0;
	localparam logic [2:0] PWR_MODE_FULL_DOWN = 3'h1;
	localparam logic [2:0] PWR_MODE_STANDBY = 3'h2;
	// divider_sync_control fields
	localparam int SYNC_EN_BIT = 0;
	localparam int SYNC_ONESHOT_BIT = 1;
	localparam int DIV_RATIO_LSB = 4;
	localparam int DIV_RATIO_W = 3;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 100;
	localparam int STAB_MIN_MHZ = 20;
	localparam int RELOCK_MAX_NS = 5000;
	localparam int RELOCK_CYC = RELOCK_MAX_NS * CLK_MHZ / 1000;
	localparam int STANDBY_WAKE_CYC = 4;
	localparam int WAKE_CNT_W = 16;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {CDSPC_RUN, CDSPC_DOWN, CDSPC_SLEEP, CDSPC_WAKE} cdspc_pwr_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [8:0] addr;
		logic [7:0] wdata;
	} cdspc_reg_req_t;
endpackage

// ===== core/cdspc_divider.sv
// module: integer clock divider with realignment and duty-cycle stabiliser
`timescale 1ns/1ns
module cdspc_divider #(
	parameter int RATIO_W = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic realign,
	input wire logic [RATIO_W-1:0] ratio_m1,
	input wire logic stab_en,
	output logic conv_clk,
	output logic sample_en
);
	// the ratio field of the sync register is fixed, so other widths cannot be served
	if (RATIO_W != cdspc_pkg::DIV_RATIO_W) begin
		$error("divider ratio width unsupported");
	end
	logic [RATIO_W-1:0] cnt_reg, cnt_next;
	logic conv_reg, conv_next;
	logic [RATIO_W:0] half;

	// high time is half the period when stabilised, else one input cycle
	always_comb begin
		half = ({1'b0, ratio_m1} + {{RATIO_W{1'b0}}, 1'b1}) >> 1;
		cnt_next = cnt_reg;
		conv_next = conv_reg;
		if (!run || realign) begin
			cnt_next = '0;
			conv_next = 1'b0;
		end else begin
			cnt_next = (cnt_reg == ratio_m1) ? '0 : cnt_reg + 1'b1;
			if (cnt_next == '0) conv_next = 1'b1;
			else if (stab_en) conv_next = ({1'b0, cnt_next} < half);
			else conv_next = 1'b0;
			if (ratio_m1 == '0) conv_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			conv_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			conv_reg <= conv_next;
		end
	end

	assign conv_clk = conv_reg;
	// samples are taken as the conversion clock rises
	assign sample_en = run && !realign && (cnt_next == '0);

	realign_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		realign |=> cnt_reg == '0) else $error("divider not reset by realign");
	ratio_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		run && !realign && cnt_reg == ratio_m1 && $stable(ratio_m1) |=> cnt_reg == '0)
		else $error("divider missed wrap");
	sample_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
		sample_en |=> conv_clk) else $error("sample without rising clock");
endmodule

// ===== core/cdspc_top.sv
// module: clock divider, sync alignment and power-state control top
`timescale 1ns/1ns
module cdspc_top #(
	parameter int WAKE_W = cdspc_pkg::WAKE_CNT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire cdspc_pkg::cdspc_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic sync_pulse,
	input wire logic power_off_pin,
	input wire logic duty_cycle_stabiliser,
	output logic conv_clk,
	output logic sample_en,
	output logic ref_powered,
	output logic ready,
	output logic out_oe_n,
	output logic [2:0] power_mode
);
	// ****************************************
	// parameter checks
	// ****************************************
	// below four bits is refused, though three bits already hold the standby wake count; above 31 int maths overflows
	if (WAKE_W < 4 || WAKE_W > 31) begin
		$error("wake counter width unsupported");
	end
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] pmode_reg, pmode_next, sctl_reg, sctl_next;
	logic armed_reg, armed_next;
	logic [7:0] rdata_reg, rdata_next;
	logic hit_pm, hit_sc;
	logic [2:0] mode;
	logic realign;

	// register decode, write update and read capture
	always_comb begin
		hit_pm = reg_req.addr == cdspc_pkg::POWER_MODE_SELECT_OFS;
		hit_sc = reg_req.addr == cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS;
		pmode_next = pmode_reg;
		sctl_next = sctl_reg;
		armed_next = armed_reg;
		rdata_next = rdata_reg;
		if (reg_req.wr && hit_pm) pmode_next = reg_req.wdata;
		// only a pulse that really realigns consumes the arm; a write re-arms it
		if (realign && sctl_reg[cdspc_pkg::SYNC_ONESHOT_BIT]) armed_next = 1'b0;
		if (reg_req.wr && hit_sc) begin
			sctl_next = reg_req.wdata;
			armed_next = 1'b1;
		end
		if (reg_req.rd) begin
			if (hit_pm) rdata_next = pmode_reg;
			else if (hit_sc) rdata_next = sctl_reg;
			else rdata_next = 8'h00;
		end
	end

	// register file state, synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pmode_reg <= cdspc_pkg::POWER_MODE_SELECT_RST;
			sctl_reg <= cdspc_pkg::DIVIDER_SYNC_CONTROL_RST;
			armed_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			pmode_reg <= pmode_next;
			sctl_reg <= sctl_next;
			armed_reg <= armed_next;
			rdata_reg <= rdata_next;
		end
	end

	// live mode field and registered read port
	assign mode = pmode_reg[cdspc_pkg::PWR_MODE_LSB +: cdspc_pkg::PWR_MODE_W];
	assign reg_rdata = rdata_reg;
	assign power_mode = mode;

	// ****************************************
	// power state
	// ****************************************
	cdspc_pkg::cdspc_pwr_t st_reg, st_next;
	logic [WAKE_W-1:0] down_reg, down_next, wake_reg, wake_next;
	logic req_down, req_sleep;

	// wake time tracks time spent down because internal nodes discharge
	always_comb begin
		req_down = power_off_pin || (mode == cdspc_pkg::PWR_MODE_FULL_DOWN);
		req_sleep = mode == cdspc_pkg::PWR_MODE_STANDBY;
		st_next = st_reg;
		down_next = down_reg;
		wake_next = wake_reg;
		unique case (st_reg)
			cdspc_pkg::CDSPC_RUN: begin
				down_next = '0;
				if (req_down) st_next = cdspc_pkg::CDSPC_DOWN;
				else if (req_sleep) st_next = cdspc_pkg::CDSPC_SLEEP;
			end
			cdspc_pkg::CDSPC_DOWN: begin
				if (~&down_reg) down_next = down_reg + 1'b1;
				if (!req_down) begin
					st_next = cdspc_pkg::CDSPC_WAKE;
					wake_next = down_reg;
				end
			end
			cdspc_pkg::CDSPC_SLEEP: begin
				if (req_down) st_next = cdspc_pkg::CDSPC_DOWN;
				else if (!req_sleep) begin
					st_next = cdspc_pkg::CDSPC_WAKE;
					wake_next = WAKE_W'(cdspc_pkg::STANDBY_WAKE_CYC);
				end
			end
			cdspc_pkg::CDSPC_WAKE: begin
				if (req_down) st_next = cdspc_pkg::CDSPC_DOWN;
				else if (wake_reg == '0) st_next = cdspc_pkg::CDSPC_RUN;
				else wake_next = wake_reg - 1'b1;
			end
		endcase
	end

	// power state and its two counters
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= cdspc_pkg::CDSPC_RUN;
			down_reg <= '0;
			wake_reg <= '0;
		end else begin
			st_reg <= st_next;
			down_reg <= down_next;
			wake_reg <= wake_next;
		end
	end

	// drivers stay enabled through standby and wake; only full power-down floats them
	assign ready = st_reg == cdspc_pkg::CDSPC_RUN;
	assign out_oe_n = st_reg == cdspc_pkg::CDSPC_DOWN;
	assign ref_powered = st_reg != cdspc_pkg::CDSPC_DOWN;

	// ****************************************
	// divider and alignment
	// ****************************************
	// every-pulse mode realigns always; one-shot only while armed
	assign realign = sync_pulse && sctl_reg[cdspc_pkg::SYNC_EN_BIT]
		&& (!sctl_reg[cdspc_pkg::SYNC_ONESHOT_BIT] || armed_reg);

	// the divider stops and clears whenever the block is not running
	cdspc_divider #(.RATIO_W(cdspc_pkg::DIV_RATIO_W)) i_cdspc_divider (
		.clk(clk),
		.rst_n(rst_n),
		.run(ready),
		.realign(realign),
		.ratio_m1(sctl_reg[cdspc_pkg::DIV_RATIO_LSB +: cdspc_pkg::DIV_RATIO_W]),
		.stab_en(duty_cycle_stabiliser),
		.conv_clk(conv_clk),
		.sample_en(sample_en)
	);

	// ****************************************
	// checks
	// ****************************************
	// power state: entry, release and wake timing
	pin_down_a: assert property (@(posedge clk) disable iff (!rst_n)
		power_off_pin |=> st_reg == cdspc_pkg::CDSPC_DOWN)
		else $error("pin ignored");
	down_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_DOWN |-> out_oe_n && !sample_en)
		else $error("drive in down");
	stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		!ready |=> !conv_clk)
		else $error("conversion clock kept running");
	pin_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_DOWN && !req_down |=> st_reg == cdspc_pkg::CDSPC_WAKE)
		else $error("no wake");
	wake_run_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_WAKE && !req_down && wake_reg == '0 |=> ready)
		else $error("wake did not finish");
	wake_scale_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_DOWN && !req_down |=> wake_reg == $past(down_reg))
		else $error("wake not scaled");
	down_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_DOWN && req_down && !(&down_reg)
		|=> down_reg == $past(down_reg) + 1'b1)
		else $error("down time not counted");
	standby_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_SLEEP |-> ref_powered && !out_oe_n)
		else $error("standby lost reference");
	sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_SLEEP && !req_down && !req_sleep
		|=> wake_reg == WAKE_W'(cdspc_pkg::STANDBY_WAKE_CYC))
		else $error("standby wake not short");

	// register file and alignment arming
	mode_field_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_req.wr && hit_pm |=> power_mode == $past(reg_req.wdata[2:0]))
		else $error("mode not stored");
	read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_req.rd && hit_sc |=> reg_rdata == $past(sctl_reg))
		else $error("sync control read wrong");
	rewrite_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_req.wr && hit_sc |=> armed_reg)
		else $error("write did not re-arm");
	arm_consume_a: assert property (@(posedge clk) disable iff (!rst_n)
		realign && sctl_reg[cdspc_pkg::SYNC_ONESHOT_BIT] && !(reg_req.wr && hit_sc)
		|=> !armed_reg)
		else $error("arm kept after realign");
	oneshot_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		sctl_reg[cdspc_pkg::SYNC_ONESHOT_BIT] && !armed_reg |-> !realign)
		else $error("second pulse realigned");
	every_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		sync_pulse && sctl_reg[cdspc_pkg::SYNC_EN_BIT]
		&& !sctl_reg[cdspc_pkg::SYNC_ONESHOT_BIT] |-> realign ##1 !conv_clk)
		else $error("pulse dropped");

	// ****************************************
	// scenario coverage
	// ****************************************
	down_c: cover property (@(posedge clk) disable iff (!rst_n)
		st_reg == cdspc_pkg::CDSPC_DOWN ##1 st_reg == cdspc_pkg::CDSPC_WAKE);
	sleep_c: cover property (@(posedge clk) disable iff (!rst_n) st_reg == cdspc_pkg::CDSPC_SLEEP);
	realign_c: cover property (@(posedge clk) disable iff (!rst_n) realign && ready);
	oneshot_c: cover property (@(posedge clk) disable iff (!rst_n)
		sync_pulse && sctl_reg[cdspc_pkg::SYNC_ONESHOT_BIT] && !armed_reg);
	stab_c: cover property (@(posedge clk) disable iff (!rst_n)
		duty_cycle_stabiliser && ready && sample_en);
endmodule

// ===== tb/cdspc_far_end.sv
// model of the system sync controller and the power-down and stabiliser pin drivers
`timescale 1ns/1ns
module cdspc_far_end (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_req,
	input wire logic pd_req,
	input wire logic stab_req,
	output logic sync_pulse,
	output logic power_off_pin,
	output logic duty_cycle_stabiliser
);
	logic last_req_reg;
	// each toggle of sync_req gives exactly one high cycle, so the bench needs no lowering edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_req_reg <= 1'b0;
			sync_pulse <= 1'b0;
			power_off_pin <= 1'b0;
			duty_cycle_stabiliser <= 1'b0;
		end else begin
			last_req_reg <= sync_req;
			sync_pulse <= sync_req ^ last_req_reg;
			power_off_pin <= pd_req;
			duty_cycle_stabiliser <= stab_req;
		end
	end
endmodule

// ===== tb/clock_divider_sync_power_control_bench.sv
// self-checking bench for the divider, sync and power control block
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module clock_divider_sync_power_control_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cdspc_pkg::cdspc_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata, rd;
	logic sync_req = 1'b0, pd_req = 1'b0, stab_req = 1'b0;
	logic sync_pulse, power_off_pin, duty_cycle_stabiliser;
	logic conv_clk, sample_en, ref_powered, ready, out_oe_n;
	logic [2:0] power_mode;
	int num_errors = 0, checks = 0, cyc = 0, n, d0, s, hi, wf, ws, w10, w20;
	always #5 clk = ~clk;
	cdspc_far_end i_cdspc_far_end (.clk(clk), .rst_n(rst_n), .sync_req(sync_req),
		.pd_req(pd_req), .stab_req(stab_req), .sync_pulse(sync_pulse),
		.power_off_pin(power_off_pin), .duty_cycle_stabiliser(duty_cycle_stabiliser));
	cdspc_top i_cdspc_top (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.sync_pulse(sync_pulse), .power_off_pin(power_off_pin),
		.duty_cycle_stabiliser(duty_cycle_stabiliser), .conv_clk(conv_clk),
		.sample_en(sample_en), .ref_powered(ref_powered), .ready(ready),
		.out_oe_n(out_oe_n), .power_mode(power_mode));
	// ****************************************
	// access and timing tasks
	// ****************************************
	task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk) reg_req.wr <= 1'b0;
	endtask
	// read data is sampled at mid-cycle, well clear of the launching edge
	task automatic reg_rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk) reg_req.rd <= 1'b0;
		@(posedge clk);
		@(negedge clk) d = reg_rdata;
	endtask
	// count mid-cycle samples up to the next sample strobe, bounded against a stuck divider
	task automatic wait_se(output int k);
		k = 0;
		do begin
			@(negedge clk) k++;
		end while (sample_en !== 1'b1 && k < 50);
	endtask
	task automatic sync_meas(input int skip, output int k);
		repeat (skip) @(posedge clk);
		@(posedge clk) sync_req <= ~sync_req;
		wait_se(k);
	endtask
	task automatic down_wake(input int k, output int w);
		@(posedge clk) pd_req <= 1'b1;
		repeat (k) @(posedge clk);
		@(negedge clk) `CHK(out_oe_n, 1'b1)
		`CHK(ready, 1'b0)
		@(posedge clk) pd_req <= 1'b0;
		wait_ready(w);
		`CHK(out_oe_n, 1'b0)
	endtask
	task automatic wait_ready(output int w);
		w = 0;
		do begin
			@(negedge clk) w++;
		end while (ready !== 1'b1 && w < 500);
	endtask
	task automatic reg_down(input logic [7:0] m, output int w);
		reg_wr(cdspc_pkg::POWER_MODE_SELECT_OFS, m);
		repeat (10) @(posedge clk);
		@(negedge clk) `CHK(out_oe_n, (m == 8'h01))
		`CHK(power_mode, m[2:0])
		`CHK(ref_powered, (m == 8'h02))
		reg_wr(cdspc_pkg::POWER_MODE_SELECT_OFS, 8'h00);
		wait_ready(w);
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// timeout well above the fewer than one thousand cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk) `CHK({ready, out_oe_n}, 2'b10)
		reg_rd(cdspc_pkg::POWER_MODE_SELECT_OFS, rd);
		`CHK(rd, cdspc_pkg::POWER_MODE_SELECT_RST)
		reg_rd(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, rd);
		`CHK(rd, cdspc_pkg::DIVIDER_SYNC_CONTROL_RST)
		reg_wr(9'h101, 8'hFF);
		reg_rd(9'h101, rd);
		`CHK(rd, 8'h00)
		// every ratio from /1 to /8, period taken after the divider settles
		for (int r = 0; r < 8; r++) begin
			reg_wr(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'(r << 4));
			reg_rd(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, rd);
			`CHK(rd, 8'(r << 4))
			wait_se(n);
			wait_se(n);
			wait_se(n); `CHK(n, r + 1)
		end
		// divide by four with the stabiliser on: two high cycles, first right after the strobe
		@(posedge clk) stab_req <= 1'b1;
		reg_wr(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h30);
		// the stabiliser is only trusted once its relock interval has passed
		repeat (cdspc_pkg::RELOCK_CYC) @(posedge clk);
		wait_se(n);
		wait_se(n);
		hi = 0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk) hi += conv_clk;
			if (i == 0) `CHK(conv_clk, 1'b1)
		end
		`CHK(hi, 2)
		// realign on every pulse, then first pulse only, then re-arm by rewrite
		reg_wr(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h71);
		wait_se(n);
		sync_meas(0, d0);
		s = (d0 == 5) ? 2 : 3;
		sync_meas(s, n); `CHK(n, d0)
		reg_wr(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h73);
		wait_se(n);
		sync_meas(0, n); `CHK(n, d0)
		sync_meas(s, n); `CHK(n, 8 - s)
		reg_wr(cdspc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h73);
		wait_se(n);
		sync_meas(0, n); `CHK(n, d0)
		// wake time grows with time spent down; standby wakes sooner
		down_wake(10, w10);
		down_wake(20, w20);
		`CHK(w20 - w10, 10)
		reg_down(8'h01, wf);
		reg_down(8'h02, ws);
		`CHK(ws < wf, 1'b1)
		// codes beyond the named modes leave the converter running
		reg_wr(cdspc_pkg::POWER_MODE_SELECT_OFS, 8'h05);
		repeat (2) @(posedge clk);
		@(negedge clk) `CHK(power_mode, 3'h5)
		`CHK({ready, out_oe_n, ref_powered}, 3'b101)
		wrap_up();
	end
endmodule
